// ===== verilog/usc_uart.sv
`timescale 1ns/1ps
`include "usc_params.svh"
// How it works
// - tx complete sets when tx empty and nothing sent; armed write clears.
// - word moving to receive register sets rx full and may raise irq.
// - noise, framing, parity flags set in same cycle as rx full.
// - rx full clears on armed data read when no more data buffered.
// - rx idle low from start detection to the mid-bit stop vote, high otherwise.
// - overrun sets on buffer overflow, blocks loads; armed access clears.
// - framing flag sets on bad stop bit; armed access clears.
// - noise flag sets with rx full, never for lost words.
// - parity error flag only while parity enabled; armed access clears.
// - nine bit mode sends and receives a ninth data bit.
// - break holds line low at least 13 bits and until cleared.
// - two stop bits when selected, else one.
// - parity generated and checked only when on; odd or even.
// - uart off releases both pins; on gives pins per direction enables.
// - uart off aborts, empties buffer, resets counter and flags.
// - tx empty rising raises irq when its enable is set.
// - tx complete rising raises irq when its enable is set.
// - overrun or rx full rising raises irq when enabled.
// - falling receive edge in power down wakes when enabled.
// - address detect keeps only words whose last data bit is one.
// - clearing a direction enable aborts and resets that side.
// - free 8-bit divider, bit rate clock over 64 or 16 times N+1.
// - tx empty sets on shifter load or tx enable; armed write clears.
// - frames are start, data lsb first, parity, stop bits.
// - transmit pin idles high while owned and not sending.
// - two word receive fifo ahead of the receive data register.
module usc_uart
#(
  parameter int RX_DEPTH = 2
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_in,
  input  wire logic        power_down,
  output logic             tx_out,
  output logic             tx_oe,
  output logic             rx_sel,
  output logic             irq,
  output logic             wake
);
  localparam int PW = $clog2(RX_DEPTH);

  logic [31:0]          prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [7:0]           ctla_r;
  logic [7:0]           ctlb_r;
  logic [7:0]           baud_r;
  logic [7:0]           stat_r;
  logic [7:0]           arm_r;
  logic [7:0]           prev_r;
  logic [7:0]           bcnt_r;
  logic [1:0]           pre_r;
  usc_pkg::usc_tx_e     tx_st_r;
  logic [11:0]          tx_sh_r;
  logic [3:0]           tx_cnt_r;
  logic [3:0]           tx_ph_r;
  logic [7:0]           hold_r;
  logic                 hold_full_r;
  logic                 tx_out_r;
  logic                 tx_oe_r;
  logic                 rx_sel_r;
  logic                 irq_r;
  logic                 wake_r;
  logic                 rxq_r;
  usc_pkg::usc_rx_e     rx_st_r;
  logic [3:0]           rx_ph_r;
  logic [3:0]           rx_cnt_r;
  logic [9:0]           rx_sh_r;
  logic [1:0]           smp_r;
  logic                 rx_nf_r;
  usc_pkg::usc_word_s   fifo_m [RX_DEPTH];
  logic [PW-1:0]        wp_r;
  logic [PW-1:0]        rp_r;
  logic [PW:0]          fcnt_r;
  usc_pkg::usc_word_s   rxr_r;
  logic                 rxr_has_r;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire setup  = psel & ~penable;
  wire acc    = psel & penable & pready_r;
  wire wr     = acc & pwrite;
  wire rd     = acc & ~pwrite;
  wire hit_st = paddr == `USC_OFF_STAT;
  wire hit_a  = paddr == `USC_OFF_CTLA;
  wire hit_b  = paddr == `USC_OFF_CTLB;
  wire hit_bd = paddr == `USC_OFF_BAUD;
  wire hit_d  = paddr == `USC_OFF_DATA;
  wire hit    = hit_st | hit_a | hit_b | hit_bd | hit_d;
  wire dwr    = wr & hit_d;
  wire drd    = rd & hit_d;
  wire dacc   = acc & hit_d;

  wire uon   = ctla_r[`USC_A_ON];
  wire nine  = ctla_r[`USC_A_NINE];
  wire par   = ctla_r[`USC_A_PAR];
  wire odd   = ctla_r[`USC_A_ODD];
  wire ton   = ctlb_r[`USC_B_TXON] & uon;
  wire ron   = ctlb_r[`USC_B_RXON] & uon;

  wire [7:0] ctla_rd = {ctla_r[7:2], rxr_r.data[8], ctla_r[0]};
  wire [7:0] rd_mux  = hit_st ? stat_r :
                       hit_a  ? ctla_rd :
                       hit_b  ? ctlb_r :
                       hit_bd ? baud_r :
                       hit_d  ? rxr_r.data[7:0] : 8'h00;

  // off clears break and both direction enables
  wire [7:0] ctla_w   = (wr & hit_a) ? (pwdata[7:0] & `USC_A_WMASK)
                                     : ctla_r;
  wire [7:0] ctlb_w   = (wr & hit_b) ? pwdata[7:0] : ctlb_r;
  wire       on_nxt   = ctla_w[`USC_A_ON];
  wire [7:0] ctla_nxt = on_nxt ? ctla_w : (ctla_w & `USC_A_OFFCLR);
  wire [7:0] ctlb_nxt = on_nxt ? ctlb_w : (ctlb_w & `USC_B_OFFCLR);
  wire       ton_rise = ctlb_nxt[`USC_B_TXON] & ~ctlb_r[`USC_B_TXON];

  // ----------------------------------------
  // bus registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      ctla_r    <= `USC_CTLA_RST;
      ctlb_r    <= `USC_CTLB_RST;
      baud_r    <= `USC_BAUD_RST;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      prdata_r  <= setup ? {24'h00_0000, rd_mux} : prdata_r;
      ctla_r    <= ctla_nxt;
      ctlb_r    <= ctlb_nxt;
      baud_r    <= (wr & hit_bd) ? pwdata[7:0] : baud_r;
    end
  end

  // ----------------------------------------
  // baud generator
  // ----------------------------------------
  wire btick = uon & (bcnt_r == baud_r);
  wire stick = btick & (ctlb_r[`USC_B_HS] | (pre_r == `USC_LS_PRE));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bcnt_r <= 8'h00;
      pre_r  <= 2'h0;
    end
    else
    begin
      bcnt_r <= (!uon || btick) ? 8'h00 : bcnt_r + 8'h01;
      pre_r  <= !uon ? 2'h0 : (btick ? pre_r + 2'h1 : pre_r);
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  wire        tx_bend = stick & (tx_ph_r == `USC_PH_LAST);
  wire [8:0]  txd  = nine ? {ctla_r[`USC_A_TX9], hold_r}
                          : {1'b0, hold_r};
  wire        tpb  = ~par | (^txd ^ odd);
  // start, data lsb first, parity, stop bits
  wire [11:0] tfrm = nine ? {1'b1, tpb, txd, 1'b0}
                          : {2'h3, tpb, txd[7:0], 1'b0};
  wire [3:0]  tlen = 4'hA + {3'h0, nine} + {3'h0, par}
                   + {3'h0, ctla_r[`USC_A_STOP2]};
  wire        tx_idle = tx_st_r == usc_pkg::TX_IDLE;
  wire        tload   = tx_idle & hold_full_r & ton;
  wire        tbrk    = tx_idle & ~hold_full_r & ton
                      & ctla_r[`USC_A_BRK];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_r     <= usc_pkg::TX_IDLE;
      tx_sh_r     <= 12'hFFF;
      tx_cnt_r    <= 4'h0;
      tx_ph_r     <= 4'h0;
      hold_r      <= 8'h00;
      hold_full_r <= 1'b0;
    end
    else if (!ton)
    begin
      tx_st_r     <= usc_pkg::TX_IDLE;
      tx_ph_r     <= 4'h0;
      hold_full_r <= 1'b0;
    end
    else
    begin
      tx_ph_r <= tx_idle ? 4'h0 : (stick ? tx_ph_r + 4'h1 : tx_ph_r);
      if (tload)
        hold_full_r <= 1'b0;
      if (dwr)
      begin
        hold_r      <= pwdata[7:0];
        hold_full_r <= 1'b1;
      end
      case (tx_st_r)
        usc_pkg::TX_IDLE:
        begin
          if (tload)
          begin
            tx_sh_r  <= tfrm;
            tx_cnt_r <= tlen;
            tx_st_r  <= usc_pkg::TX_SHIFT;
          end
          else if (tbrk)
          begin
            tx_cnt_r <= `USC_BRK_BITS;
            tx_st_r  <= usc_pkg::TX_BRK;
          end
        end
        usc_pkg::TX_SHIFT:
        begin
          if (tx_bend)
          begin
            tx_sh_r  <= {1'b1, tx_sh_r[11:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h1)
              tx_st_r <= usc_pkg::TX_IDLE;
          end
        end
        usc_pkg::TX_BRK:
        begin
          if (tx_bend && tx_cnt_r != 4'h0)
            tx_cnt_r <= tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h0 && !ctla_r[`USC_A_BRK])
            tx_st_r <= usc_pkg::TX_IDLE;
        end
        default:
          tx_st_r <= usc_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  wire maj   = (smp_r[0] & smp_r[1]) | (smp_r[0] & rx_in)
             | (smp_r[1] & rx_in);
  wire noisy = ~((smp_r[0] == smp_r[1]) && (smp_r[1] == rx_in));
  wire at_vote = stick & (rx_ph_r == `USC_PH_VOTE);
  wire rbend   = stick & (rx_ph_r == `USC_PH_LAST);
  wire [3:0] rlen = 4'h8 + {3'h0, nine} + {3'h0, par};
  wire [9:0] ral  = rx_sh_r >> (4'hA - rlen);
  wire [8:0] rdat = nine ? ral[8:0] : {1'b0, ral[7:0]};
  wire       rpb  = nine ? ral[9] : ral[8];
  usc_pkg::usc_word_s rw;
  assign rw = {rdat, ~maj, par & (^rdat ^ rpb ^ odd),
               rx_nf_r | noisy};
  wire addr_bit = nine ? rdat[8] : rdat[7];
  wire rdone = ron & at_vote & (rx_st_r == usc_pkg::RX_STOP);
  wire keep  = ~ctlb_r[`USC_B_ADDR] | addr_bit;
  wire full  = fcnt_r == (PW+1)'(RX_DEPTH);
  wire push  = rdone & keep & ~full;
  wire ovf   = rdone & keep & full;
  usc_pkg::usc_word_s hd;
  assign hd = fifo_m[rp_r];
  wire mv = ron & ~rxr_has_r & (fcnt_r != '0) & ~stat_r[`USC_S_OVR];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_r  <= usc_pkg::RX_IDLE;
      rx_ph_r  <= 4'h0;
      rx_cnt_r <= 4'h0;
      rx_sh_r  <= 10'h000;
      smp_r    <= 2'h3;
      rx_nf_r  <= 1'b0;
    end
    else if (!ron)
    begin
      rx_st_r <= usc_pkg::RX_IDLE;
      rx_ph_r <= 4'h0;
      rx_nf_r <= 1'b0;
    end
    else
    begin
      if (stick && rx_ph_r == `USC_PH_S0)
        smp_r[0] <= rx_in;
      if (stick && rx_ph_r == `USC_PH_S1)
        smp_r[1] <= rx_in;
      rx_ph_r <= (rx_st_r == usc_pkg::RX_IDLE) ? 4'h0
               : (stick ? rx_ph_r + 4'h1 : rx_ph_r);
      case (rx_st_r)
        usc_pkg::RX_IDLE:
        begin
          if (stick && !rx_in)
            rx_st_r <= usc_pkg::RX_START;
        end
        usc_pkg::RX_START:
        begin
          if (at_vote)
            rx_nf_r <= noisy;
          if (at_vote && maj)
            rx_st_r <= usc_pkg::RX_IDLE;
          else if (rbend)
          begin
            rx_cnt_r <= rlen;
            rx_st_r  <= usc_pkg::RX_DATA;
          end
        end
        usc_pkg::RX_DATA:
        begin
          if (at_vote)
          begin
            rx_sh_r  <= {maj, rx_sh_r[9:1]};
            rx_cnt_r <= rx_cnt_r - 4'h1;
            rx_nf_r  <= rx_nf_r | noisy;
          end
          if (rbend && rx_cnt_r == 4'h0)
            rx_st_r <= usc_pkg::RX_STOP;
        end
        usc_pkg::RX_STOP:
        begin
          if (at_vote)
            rx_st_r <= usc_pkg::RX_IDLE;
        end
        default:
          rx_st_r <= usc_pkg::RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive fifo and data register
  // ----------------------------------------
  always_ff @(posedge pclk)
  begin
    if (push)
      fifo_m[wp_r] <= rw;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_r      <= '0;
      rp_r      <= '0;
      fcnt_r    <= '0;
      rxr_r     <= '0;
      rxr_has_r <= 1'b0;
    end
    else if (!ron)
    begin
      wp_r      <= '0;
      rp_r      <= '0;
      fcnt_r    <= '0;
      rxr_has_r <= 1'b0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + PW'(1);
      if (mv)
      begin
        rxr_r     <= hd;
        rp_r      <= rp_r + PW'(1);
        rxr_has_r <= 1'b1;
      end
      else if (drd)
        rxr_has_r <= 1'b0;
      fcnt_r <= fcnt_r + (PW+1)'(push) - (PW+1)'(mv);
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  wire txc_cond = stat_r[`USC_S_TXE] & ~hold_full_r & tx_idle
                & ~ctla_r[`USC_A_BRK] & ~dwr;
  wire [7:0] st_set = {tload | ton_rise,
                       txc_cond,
                       mv,
                       1'b0,
                       ovf,
                       mv & hd.nf,
                       mv & hd.fe,
                       mv & hd.pe};
  wire [7:0] st_clr = arm_r & {dwr, dwr,
                               drd & (fcnt_r == '0),
                               1'b0, {4{dacc}}};
  wire [7:0] st_keep = st_set | (stat_r & ~st_clr);
  wire [7:0] stat_nxt = !uon ? `USC_STAT_OFF
                      : {st_keep[7:5],
                         rx_st_r == usc_pkg::RX_IDLE,
                         st_keep[3:0]};
  wire [7:0] irq_msk = {ctlb_r[`USC_B_TX_EMPTY_IRQ_EN], ctlb_r[`USC_B_TX_IDLE_IRQ_EN],
                        ctlb_r[`USC_B_RIE], 1'b0,
                        ctlb_r[`USC_B_RIE], 3'h0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_r <= `USC_STAT_OFF;
      arm_r  <= 8'h00;
      prev_r <= `USC_STAT_OFF;
      irq_r  <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (!uon || dacc)
        arm_r <= 8'h00;
      else if (rd && hit_st)
        arm_r <= prdata_r[7:0];
      prev_r <= stat_r;
      irq_r  <= uon & (|(stat_r & ~prev_r & irq_msk));
    end
  end

  // ----------------------------------------
  // pins and wake
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_out_r <= 1'b1;
      tx_oe_r  <= 1'b0;
      rx_sel_r <= 1'b0;
      rxq_r    <= 1'b1;
      wake_r   <= 1'b0;
    end
    else
    begin
      tx_out_r <= (tx_st_r == usc_pkg::TX_SHIFT) ? tx_sh_r[0]
                : (tx_st_r != usc_pkg::TX_BRK);
      tx_oe_r  <= ton;
      rx_sel_r <= ron;
      rxq_r    <= rx_in;
      wake_r   <= power_down & ctlb_r[`USC_B_WAKE]
                & rxq_r & ~rx_in;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign tx_out  = tx_out_r;
  assign tx_oe   = tx_oe_r;
  assign rx_sel  = rx_sel_r;
  assign irq     = irq_r;
  assign wake    = wake_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_txc;
    $rose(stat_r[`USC_S_TXC]) && $past(uon) |->
      $past(stat_r[`USC_S_TXE]) && !$past(hold_full_r) && $past(tx_idle);
  endproperty
  a_txc: assert property (p_txc) else $error("tx complete bad");
  property p_rxf;
    mv |=> stat_r[`USC_S_RXF] && rxr_has_r;
  endproperty
  a_rxf: assert property (p_rxf) else $error("rx full missed");
  property p_errs;
    mv && hd.fe |=> stat_r[`USC_S_FE] && stat_r[`USC_S_RXF];
  endproperty
  a_errs: assert property (p_errs) else $error("fe not with rxf");
  property p_idle;
    rx_st_r != usc_pkg::RX_IDLE && uon |=> !stat_r[`USC_S_RXI];
  endproperty
  a_idle: assert property (p_idle) else $error("rx idle high");
  property p_ovr;
    stat_r[`USC_S_OVR] && !rxr_has_r |=> !rxr_has_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("load in overrun");
  property p_brk;
    tx_st_r == usc_pkg::TX_BRK |=> !tx_out_r;
  endproperty
  a_brk: assert property (p_brk) else $error("break not low");
  property p_pins;
    !uon |=> !tx_oe_r && !rx_sel_r;
  endproperty
  a_pins: assert property (p_pins) else $error("pins kept");
  property p_off;
    !uon |=> stat_r == `USC_STAT_OFF;
  endproperty
  a_off: assert property (p_off) else $error("off flags bad");
  property p_irq_te;
    $rose(stat_r[`USC_S_TXE]) && ctlb_r[`USC_B_TX_EMPTY_IRQ_EN] && uon |=> irq_r;
  endproperty
  a_irq_te: assert property (p_irq_te) else $error("no te irq");
  property p_irq_rx;
    $rose(stat_r[`USC_S_RXF]) && ctlb_r[`USC_B_RIE] && uon |=> irq_r;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("no rx irq");
  property p_baud;
    btick |=> bcnt_r == 8'h00;
  endproperty
  a_baud: assert property (p_baud) else $error("divider wrap");

  c_move: cover property (mv);
  c_brk:  cover property (tx_st_r == usc_pkg::TX_BRK);
  c_ovf:  cover property (ovf);
  c_wake: cover property (wake_r);
endmodule

// ===== verilog/usc_params.svh
`ifndef USC_PARAMS_SVH
`define USC_PARAMS_SVH
// register offsets
`define USC_OFF_STAT  8'h00
`define USC_OFF_CTLA  8'h04
`define USC_OFF_CTLB  8'h08
`define USC_OFF_BAUD  8'h0C
`define USC_OFF_DATA  8'h10
// uart_status bits
`define USC_S_TXE     7
`define USC_S_TXC     6
`define USC_S_RXF     5
`define USC_S_RXI     4
`define USC_S_OVR     3
`define USC_S_NF      2
`define USC_S_FE      1
`define USC_S_PE      0
// uart_control_a bits
`define USC_A_ON      7
`define USC_A_NINE    6
`define USC_A_PAR     5
`define USC_A_ODD     4
`define USC_A_STOP2   3
`define USC_A_BRK     2
`define USC_A_TX9     0
// uart_control_b bits
`define USC_B_TXON    7
`define USC_B_RXON    6
`define USC_B_HS      5
`define USC_B_ADDR    4
`define USC_B_WAKE    3
`define USC_B_RIE     2
`define USC_B_TX_IDLE_IRQ_EN    1
`define USC_B_TX_EMPTY_IRQ_EN    0
// reset values and masks
`define USC_CTLA_RST  8'h00
`define USC_CTLB_RST  8'h00
`define USC_BAUD_RST  8'h00
`define USC_STAT_OFF  8'hD0
`define USC_A_WMASK   8'hFD
`define USC_A_OFFCLR  8'hFB
`define USC_B_OFFCLR  8'h3F
// timing
`define USC_LS_PRE    2'h3
`define USC_PH_LAST   4'hF
`define USC_PH_S0     4'h7
`define USC_PH_S1     4'h8
`define USC_PH_VOTE   4'h9
`define USC_BRK_BITS  4'hD
`endif

// ===== verilog/usc_pkg.sv
package usc_pkg;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h1,
    TX_SHIFT = 3'h2,
    TX_BRK   = 3'h4
  } usc_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } usc_rx_e;
  typedef struct packed {
    logic [8:0] data;
    logic       fe;
    logic       pe;
    logic       nf;
  } usc_word_s;
endpackage

// ===== tb/usc_peer.sv
`timescale 1ns/1ps
// ----
// far serial end, BIT clocks per bit
// ----
module usc_peer
#(
  parameter int BIT = 16
)
(
  input  wire logic pclk,
  input  wire logic tx_out,
  input  wire logic tx_oe,
  output logic      rx_in
);
  initial rx_in = 1'b1;
  task automatic send(input logic [7:0] d, input logic pb, input logic sb);
    logic [10:0] f;
    f = {sb, pb, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_in <= f[i];
      repeat (BIT) @(posedge pclk);
    end
    if (!sb)
    begin
      rx_in <= 1'b1;
      @(posedge pclk);
    end
  endtask
  // returns data, extra bit and stop level sampled mid-bit
  task automatic recv(input logic ext, output logic [9:0] d);
    int n;
    d = '0;
    n = 0;
    while (!(tx_oe === 1'b1 && tx_out === 1'b0) && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < (ext ? 10 : 9); i++)
    begin
      repeat (BIT) @(posedge pclk);
      d[i] = tx_out;
    end
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_in, power_down, tx_out, tx_oe, rx_sel, irq, wake, err, p;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  got;
  logic [7:0]  fmt [5] = '{8'h80, 8'hA0, 8'hB0, 8'h88, 8'hC1};
  logic [7:0]  rxq [$];
  int          mismatches, check_count, cyc, irqs, wakes, lows, i;
  usc_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .power_down(power_down), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_sel(rx_sel), .irq(irq), .wake(wake));
  usc_peer peer (.pclk(pclk), .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    irqs += (irq === 1'b1);
    wakes += (wake === 1'b1);
    lows += (tx_out === 1'b0);
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    {presetn, psel, penable, pwrite, power_down} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(89292));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 8'h00);
    chk(32'hD0, rd);
    apb(0, 8'h14, 8'h00);
    chk(1, err);
    apb(1, 8'h04, 8'h80);
    apb(1, 8'h08, 8'hE4);
    @(posedge pclk);
    chk(2'b11, {tx_oe, rx_sel});
    for (i = 0; i < 5; i++)
    begin
      b = $urandom;
      apb(1, 8'h04, fmt[i]);
      apb(0, 8'h00, 8'h00);
      fork
        apb(1, 8'h10, b);
        peer.recv(fmt[i][5] | fmt[i][6], got);
      join
      p = fmt[i][6] ? fmt[i][0] : ^b ^ fmt[i][4];
      chk(fmt[i][6:5] != 0 ? {1'b1, p, b} : {2'b01, b}, got);
      repeat (48) @(posedge pclk);
      apb(0, 8'h00, 8'h00);
      chk(1, rd[6]);
    end
    apb(1, 8'h04, 8'hA0);
    for (i = 0; i < 3; i++)
    begin
      b = $urandom;
      irqs = 0;
      rxq.push_back(b);
      peer.send(b, ^b ^ (i == 1), i != 2);
      repeat (16) @(posedge pclk);
      apb(0, 8'h00, 8'h00);
      chk({4'b1100, i == 2, i == 1}, rd[5:0]);
      chk(1, irqs != 0);
      apb(0, 8'h10, 8'h00);
      chk(rxq.pop_front(), rd);
      apb(0, 8'h00, 8'h00);
      chk(6'h10, rd[5:0]);
    end
    for (i = 0; i < 4; i++)
    begin
      b = $urandom;
      if (i < 3)
        rxq.push_back(b);
      peer.send(b, ^b, 1'b1);
    end
    apb(0, 8'h00, 8'h00);
    chk(1, rd[3]);
    while (rxq.size() > 0)
    begin
      apb(0, 8'h00, 8'h00);
      apb(0, 8'h10, 8'h00);
      chk(rxq.pop_front(), rd);
    end
    apb(0, 8'h00, 8'h00);
    chk(3'b010, rd[5:3]);
    apb(1, 8'h04, 8'hC0);
    apb(1, 8'h08, 8'hF4);
    for (i = 0; i < 2; i++)
    begin
      b = $urandom;
      irqs = 0;
      peer.send(b, i[0], 1'b1);
      repeat (16) @(posedge pclk);
      apb(0, 8'h04, 8'h00);
      chk({i[0], 1'b0}, rd[1:0]);
      chk(i, irqs != 0);
      apb(0, 8'h00, 8'h00);
      chk(i, rd[5]);
      apb(0, 8'h10, 8'h00);
      if (i == 1)
        chk(b, rd);
    end
    apb(1, 8'h08, 8'hEC);
    wakes = 0;
    power_down <= 1'b1;
    peer.send(8'h55, 1'b0, 1'b1);
    power_down <= 1'b0;
    chk(1, wakes != 0);
    lows = 0;
    apb(1, 8'h04, 8'h84);
    repeat (13 * 16) @(posedge pclk);
    apb(1, 8'h04, 8'h80);
    repeat (20) @(posedge pclk);
    chk(1, lows >= 13 * 16);
    chk(1, tx_out);
    apb(1, 8'h04, 8'h00);
    apb(0, 8'h00, 8'h00);
    chk(32'hD0, rd);
    apb(0, 8'h08, 8'h00);
    chk(32'h2C, rd);
    chk(2'b00, {tx_oe, rx_sel});
    stop_test();
  end
endmodule
